/* core/pdrs_top.sv */
// dma status register and read-channel address registers
//
// Contract
// - status register at 0x04 is 32 bits and resets to all zeros
// - bit 22 is read-only, shows eprom load failure
// - bits 21..19 show write fifo underrun, full, empty
// - bits 18..16 show read fifo overrun, full, empty
// - bit 8 sets on master timeout from either timer, write 1 clears
// - bit 7 sets on line-side interrupt, write 1 clears
// - bit 6 sets on watchdog expiry, write 1 clears
// - bit 5 sets on target abort of own transaction, write 1 clears
// - bit 4 sets on master abort of own transaction, write 1 clears
// - bit 3 sets at read channel end of buffer, write 1 clears
// - bit 2 sets at read channel interrupt address, write 1 clears
// - bit 1 sets at write channel interrupt address, write 1 clears
// - bit 0 sets at write channel end of buffer, write 1 clears
// - read start address register at 0x08, read/write, resets zero
// - read stop address register at 0x0c, read/write, resets zero
// - read interrupt address register at 0x10, read/write, resets zero
// - current read address at 0x14, read-only, resets zero
// - control bit chooses sticky or non-sticky address and end-of-buffer flags
// - each event has its own enable; disabled events raise no interrupt
`timescale 1ns/100ps
`default_nettype none
`include "pdrs_defs.svh"
module pdrs_top
	import pdrs_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic reg_sel_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [3:0] reg_be_in,
	input wire logic [31:0] reg_wdata_in,
	output logic [31:0] reg_rdata_out,
	input wire logic eprom_load_fail_in,
	input wire logic line_busy_in,
	input wire logic wr_fifo_underrun_in,
	input wire logic wr_fifo_full_in,
	input wire logic wr_fifo_empty_in,
	input wire logic rd_fifo_overrun_in,
	input wire logic rd_fifo_full_in,
	input wire logic rd_fifo_empty_in,
	input wire logic trdy_timeout_in,
	input wire logic retry_timeout_in,
	input wire logic line_side_irq_in,
	input wire logic watchdog_expired_in,
	input wire logic target_abort_in,
	input wire logic master_abort_in,
	input wire logic wr_addr_match_in,
	input wire logic wr_end_of_buffer_in,
	input wire logic rd_xfer_done_in,
	output logic rd_active_out,
	output logic [31:0] rd_current_address_out,
	output logic irq_b_out
);
	logic rst_m_r;
	logic rst_s_r;
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [31:0] ctrl_r;
	logic [31:0] rd_start_address_r;
	logic [31:0] rd_stop_address_r;
	logic [31:0] rd_irq_address_r;
	logic [31:0] rd_current_address_r;
	logic [`PDRS_NUM_EVT-1:0] flags_r;
	logic [`PDRS_NUM_EVT-1:0] evt;
	logic [`PDRS_NUM_EVT-1:0] w1c;
	logic [31:0] wmask;
	logic [31:0] status_word;
	logic stat_wr;
	logic flag_stickiness_select;
	logic rd_step;
	logic rd_match_evt;
	logic rd_eob_evt;
	logic irq_b_r;
	logic rd_active_r;
	logic [31:0] rdata_r;
	pdrs_rd_state_t rd_state_r;

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_m_r <= 1'b0;
			rst_s_r <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_s_r <= rst_m_r;
		end
	end

	// pin levels from the line side and fifos pass two flops
	always_ff @(posedge clk_sys_in or negedge rst_s_r) begin
		if (!rst_s_r) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
		end else begin
			sync1_r <= {eprom_load_fail_in, line_busy_in, wr_fifo_underrun_in, wr_fifo_full_in,
				wr_fifo_empty_in, rd_fifo_overrun_in, rd_fifo_full_in, rd_fifo_empty_in};
			sync2_r <= sync1_r;
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{reg_be_in[i]}};
		end
	end

	assign stat_wr = reg_sel_in && reg_wr_in && (reg_addr_in == `PDRS_OFF_STATUS);
	assign flag_stickiness_select = ctrl_r[`PDRS_BIT_STICKY_SEL];

	always_ff @(posedge clk_sys_in or negedge rst_s_r) begin
		if (!rst_s_r) begin
			ctrl_r <= `PDRS_RST_WORD;
			rd_start_address_r <= `PDRS_RST_WORD;
			rd_stop_address_r <= `PDRS_RST_WORD;
			rd_irq_address_r <= `PDRS_RST_WORD;
		end else if (reg_sel_in && reg_wr_in) begin
			unique case (reg_addr_in)
				`PDRS_OFF_CTRL: begin
					ctrl_r <= ((ctrl_r & ~wmask) | (reg_wdata_in & wmask)) & `PDRS_CTRL_MASK;
				end
				`PDRS_OFF_RD_START: begin
					rd_start_address_r <= (rd_start_address_r & ~wmask) | (reg_wdata_in & wmask);
				end
				`PDRS_OFF_RD_STOP: begin
					rd_stop_address_r <= (rd_stop_address_r & ~wmask) | (reg_wdata_in & wmask);
				end
				`PDRS_OFF_RD_IRQ: begin
					rd_irq_address_r <= (rd_irq_address_r & ~wmask) | (reg_wdata_in & wmask);
				end
				default: begin
				end
			endcase
		end
	end

	// read channel: restart loads start, each transfer before the stop address steps one word
	assign rd_step = (rd_state_r == PDRS_RUN) && rd_xfer_done_in;
	assign rd_match_evt = rd_step && (rd_current_address_r == rd_irq_address_r);
	assign rd_eob_evt = rd_step && (rd_current_address_r == rd_stop_address_r);

	always_ff @(posedge clk_sys_in or negedge rst_s_r) begin
		if (!rst_s_r) begin
			rd_state_r <= PDRS_IDLE;
			rd_active_r <= 1'b0;
			rd_current_address_r <= `PDRS_RST_WORD;
		end else if (!ctrl_r[`PDRS_BIT_DMA_EN]) begin
			rd_state_r <= PDRS_IDLE;
			rd_active_r <= 1'b0;
		end else begin
			unique case (rd_state_r)
				PDRS_IDLE: begin
					rd_current_address_r <= rd_start_address_r;
					rd_state_r <= PDRS_RUN;
					rd_active_r <= 1'b1;
				end
				PDRS_RUN: begin
					if (rd_eob_evt) begin
						rd_state_r <= PDRS_DONE;
						rd_active_r <= 1'b0;
					end else if (rd_step) begin
						rd_current_address_r <= rd_current_address_r + `PDRS_ADDR_STEP;
					end
				end
				PDRS_DONE: begin
					if (ctrl_r[`PDRS_BIT_DMA_RESTART]) begin
						rd_state_r <= PDRS_IDLE;
					end
				end
			endcase
		end
	end

	// flag order: [8] timeout .. [0] write end of buffer
	assign evt = {trdy_timeout_in | retry_timeout_in,
		line_side_irq_in,
		watchdog_expired_in,
		target_abort_in,
		master_abort_in,
		rd_eob_evt,
		rd_match_evt,
		wr_addr_match_in,
		wr_end_of_buffer_in};

	// only ones written in enabled lanes clear; a zero leaves the flag
	assign w1c = stat_wr ? (reg_wdata_in[`PDRS_NUM_EVT-1:0] & wmask[`PDRS_NUM_EVT-1:0])
		: {`PDRS_NUM_EVT{1'b0}};

	genvar g;
	generate
		for (g = 0; g < `PDRS_NUM_EVT; g++) begin : g_flag
			always_ff @(posedge clk_sys_in or negedge rst_s_r) begin
				if (!rst_s_r) begin
					flags_r[g] <= 1'b0;
				end else if (evt[g]) begin
					flags_r[g] <= 1'b1;
				end else if (g <= `PDRS_EVT_RD_EOB && flag_stickiness_select) begin
					flags_r[g] <= 1'b0;
				end else if (w1c[g]) begin
					flags_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_comb begin
		status_word = `PDRS_RST_WORD;
		status_word[`PDRS_BIT_LINE_BUSY] = sync2_r[6];
		status_word[`PDRS_BIT_EPROM] = sync2_r[7];
		status_word[`PDRS_BIT_WR_UNDERRUN] = sync2_r[5];
		status_word[`PDRS_BIT_WR_FULL] = sync2_r[4];
		status_word[`PDRS_BIT_WR_EMPTY] = sync2_r[3];
		status_word[`PDRS_BIT_RD_OVERRUN] = sync2_r[2];
		status_word[`PDRS_BIT_RD_FULL] = sync2_r[1];
		status_word[`PDRS_BIT_RD_EMPTY] = sync2_r[0];
		status_word[`PDRS_NUM_EVT-1:0] = flags_r;
	end

	always_ff @(posedge clk_sys_in or negedge rst_s_r) begin
		if (!rst_s_r) begin
			rdata_r <= `PDRS_RST_WORD;
		end else if (reg_sel_in && !reg_wr_in) begin
			unique case (reg_addr_in)
				`PDRS_OFF_CTRL: rdata_r <= ctrl_r;
				`PDRS_OFF_STATUS: rdata_r <= status_word;
				`PDRS_OFF_RD_START: rdata_r <= rd_start_address_r;
				`PDRS_OFF_RD_STOP: rdata_r <= rd_stop_address_r;
				`PDRS_OFF_RD_IRQ: rdata_r <= rd_irq_address_r;
				`PDRS_OFF_RD_CUR: rdata_r <= rd_current_address_r;
				default: rdata_r <= `PDRS_RST_WORD;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_s_r) begin
		if (!rst_s_r) begin
			irq_b_r <= 1'b1;
		end else begin
			irq_b_r <= ~|(flags_r & ctrl_r[`PDRS_EN_LSB +: `PDRS_NUM_EVT]);
		end
	end

	assign reg_rdata_out = rdata_r;
	assign irq_b_out = irq_b_r;
	assign rd_current_address_out = rd_current_address_r;
	assign rd_active_out = rd_active_r;

	a_irq_follows: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		irq_b_out == !(|($past(flags_r) & $past(ctrl_r[`PDRS_EN_LSB +: `PDRS_NUM_EVT]))))
		else $error("interrupt does not follow enabled flags");
	a_irq_masked: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(ctrl_r[`PDRS_EN_LSB +: `PDRS_NUM_EVT] == '0) |=> irq_b_out)
		else $error("interrupt raised with all enables off");
	a_irq_clears: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(flags_r == '0) |=> irq_b_out)
		else $error("interrupt held with no flag set");
	a_timeout_sets: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(trdy_timeout_in || retry_timeout_in) |=> flags_r[`PDRS_FLG_TIMEOUT])
		else $error("timeout flag not set");
	a_line_sets: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		line_side_irq_in |=> flags_r[`PDRS_FLG_LINE])
		else $error("line flag not set");
	a_wdog_sets: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		watchdog_expired_in |=> flags_r[`PDRS_FLG_WDOG])
		else $error("watchdog flag not set");
	a_tabort_sets: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		target_abort_in |=> flags_r[`PDRS_FLG_TABORT])
		else $error("target abort flag not set");
	a_mabort_sets: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		master_abort_in |=> flags_r[`PDRS_FLG_MABORT])
		else $error("master abort flag not set");
	a_rd_eob_sets: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(rd_eob_evt && ctrl_r[`PDRS_BIT_DMA_EN]) |=>
		flags_r[`PDRS_EVT_RD_EOB] && rd_state_r == PDRS_DONE)
		else $error("read end of buffer not flagged");
	a_rd_eob_only: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(!rd_eob_evt && !flags_r[`PDRS_EVT_RD_EOB]) |=> !flags_r[`PDRS_EVT_RD_EOB])
		else $error("read end of buffer flag set without event");
	a_rd_match_sets: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		rd_match_evt |=> flags_r[`PDRS_EVT_RD_MATCH])
		else $error("read address match not flagged");
	a_rd_match_only: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(!rd_match_evt && !flags_r[`PDRS_EVT_RD_MATCH]) |=> !flags_r[`PDRS_EVT_RD_MATCH])
		else $error("read match flag set without event");
	a_wr_match_sets: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		wr_addr_match_in |=> flags_r[`PDRS_EVT_WR_MATCH])
		else $error("write match not flagged");
	a_wr_eob_sets: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		wr_end_of_buffer_in |=> flags_r[`PDRS_EVT_WR_EOB])
		else $error("write end of buffer not flagged");
	a_zero_keeps: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(stat_wr && flags_r[`PDRS_FLG_TIMEOUT] && !reg_wdata_in[`PDRS_FLG_TIMEOUT]) |=>
		flags_r[`PDRS_FLG_TIMEOUT])
		else $error("write of zero cleared a flag");
	a_one_clears: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(stat_wr && reg_be_in[0] && reg_wdata_in[`PDRS_FLG_LINE] && !line_side_irq_in) |=>
		!flags_r[`PDRS_FLG_LINE])
		else $error("write of one did not clear");
	a_set_wins: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(stat_wr && reg_be_in[0] && reg_wdata_in[`PDRS_FLG_LINE] && line_side_irq_in) |=>
		flags_r[`PDRS_FLG_LINE])
		else $error("clear beat a new event");
	a_nonsticky: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(flag_stickiness_select && !rd_match_evt) |=> !flags_r[`PDRS_EVT_RD_MATCH])
		else $error("non-sticky flag held");
	a_rd_step: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(rd_step && !rd_eob_evt && ctrl_r[`PDRS_BIT_DMA_EN]) |=>
		rd_current_address_r == $past(rd_current_address_r) + `PDRS_ADDR_STEP)
		else $error("read address did not step");
	a_start_load: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(rd_state_r == PDRS_IDLE && ctrl_r[`PDRS_BIT_DMA_EN]) |=>
		rd_current_address_r == $past(rd_start_address_r))
		else $error("start address not loaded");
	a_done_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(rd_state_r == PDRS_DONE) |=> $stable(rd_current_address_r))
		else $error("read address moved after end of buffer");
	a_cur_ro: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(reg_sel_in && reg_wr_in && reg_addr_in == `PDRS_OFF_RD_CUR
		&& !ctrl_r[`PDRS_BIT_DMA_EN]) |=> $stable(rd_current_address_r))
		else $error("current address took a write");
	a_start_wr: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(reg_sel_in && reg_wr_in && reg_addr_in == `PDRS_OFF_RD_START && reg_be_in == 4'hf) |=>
		rd_start_address_r == $past(reg_wdata_in))
		else $error("start address write lost");
	a_stop_wr: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(reg_sel_in && reg_wr_in && reg_addr_in == `PDRS_OFF_RD_STOP && reg_be_in == 4'hf) |=>
		rd_stop_address_r == $past(reg_wdata_in))
		else $error("stop address write lost");
	a_irq_addr_wr: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(reg_sel_in && reg_wr_in && reg_addr_in == `PDRS_OFF_RD_IRQ && reg_be_in == 4'hf) |=>
		rd_irq_address_r == $past(reg_wdata_in))
		else $error("interrupt address write lost");
	a_status_ro: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(reg_sel_in && !reg_wr_in && reg_addr_in == `PDRS_OFF_STATUS) |=>
		(reg_rdata_out & ~`PDRS_STATUS_USED) == `PDRS_RST_WORD
		&& reg_rdata_out[`PDRS_BIT_EPROM] == $past(sync2_r[7]))
		else $error("status reserved or eprom bit wrong");
	a_fifo_bits: assert property (@(posedge clk_sys_in) disable iff (!rst_s_r)
		(reg_sel_in && !reg_wr_in && reg_addr_in == `PDRS_OFF_STATUS) |=>
		reg_rdata_out[`PDRS_BIT_WR_UNDERRUN:`PDRS_BIT_RD_EMPTY] == $past({wr_fifo_underrun_in,
		wr_fifo_full_in, wr_fifo_empty_in, rd_fifo_overrun_in, rd_fifo_full_in,
		rd_fifo_empty_in}, `PDRS_PIN_LAT))
		else $error("fifo bits wrong");
endmodule : pdrs_top
`default_nettype wire

/* core/pdrs_defs.svh */
// register offsets, field positions and reset values for the dma status block
`ifndef PDRS_DEFS_SVH
`define PDRS_DEFS_SVH
`define PDRS_OFF_CTRL 8'h00
`define PDRS_OFF_STATUS 8'h04
`define PDRS_OFF_RD_START 8'h08
`define PDRS_OFF_RD_STOP 8'h0c
`define PDRS_OFF_RD_IRQ 8'h10
`define PDRS_OFF_RD_CUR 8'h14
`define PDRS_RST_WORD 32'h0000_0000
`define PDRS_ADDR_STEP 32'h0000_0004
`define PDRS_BIT_LINE_BUSY 23
`define PDRS_BIT_EPROM 22
`define PDRS_BIT_WR_UNDERRUN 21
`define PDRS_BIT_WR_FULL 20
`define PDRS_BIT_WR_EMPTY 19
`define PDRS_BIT_RD_OVERRUN 18
`define PDRS_BIT_RD_FULL 17
`define PDRS_BIT_RD_EMPTY 16
`define PDRS_NUM_EVT 9
`define PDRS_EN_LSB 16
`define PDRS_BIT_STICKY_SEL 6
`define PDRS_BIT_DMA_EN 8
`define PDRS_BIT_DMA_RESTART 9
`define PDRS_EVT_WR_EOB 0
`define PDRS_EVT_WR_MATCH 1
`define PDRS_EVT_RD_MATCH 2
`define PDRS_EVT_RD_EOB 3
`define PDRS_CTRL_MASK 32'h01ff_1bc3
`define PDRS_FLG_TIMEOUT 8
`define PDRS_FLG_LINE 7
`define PDRS_FLG_WDOG 6
`define PDRS_FLG_TABORT 5
`define PDRS_FLG_MABORT 4
`define PDRS_STATUS_USED 32'h00ff_01ff
`define PDRS_PIN_LAT 3
`endif

/* core/pdrs_pkg.sv */
// types for the dma status block
package pdrs_pkg;
	typedef enum logic [1:0] {
		PDRS_IDLE,
		PDRS_RUN,
		PDRS_DONE
	} pdrs_rd_state_t;
endpackage : pdrs_pkg

/* dv/pdrs_mem_model.sv */
// host memory model answering read-channel word transfers
`timescale 1ns/100ps
`default_nettype none
module pdrs_mem_model (
	input wire logic clk_in,
	input wire logic rd_active_in,
	input wire logic [3:0] gap_in,
	output logic xfer_done_out
);
	logic done_r = 1'b0;
	logic [3:0] wait_r = 4'h0;
	assign xfer_done_out = done_r;
	// one word per pulse, gap_in idle cycles between words
	always @(negedge clk_in) begin
		if (rd_active_in && wait_r == 4'h0) begin
			done_r <= 1'b1;
			wait_r <= gap_in;
		end else begin
			done_r <= 1'b0;
			if (wait_r != 4'h0) wait_r <= wait_r - 4'h1;
		end
	end
endmodule : pdrs_mem_model
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the dma status and read address block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk, rst_b, sel, wen, done, irq_b, act;
	logic [7:0] addr, ev, lv;
	logic [3:0] be, gap;
	logic [31:0] wd, rdata, cur, d, e;
	int error_cnt = 0;
	int checks_done = 0;
	// {levels, event pulses, expected status}
	logic [47:0] rows [16] = '{
		48'h00_01_00000100, 48'h00_02_00000100, 48'h00_04_00000080, 48'h00_08_00000040,
		48'h00_10_00000020, 48'h00_20_00000010, 48'h00_40_00000002, 48'h00_80_00000001,
		48'h01_00_00010000, 48'h02_00_00020000, 48'h04_00_00040000, 48'h08_00_00080000,
		48'h10_00_00100000, 48'h20_00_00200000, 48'h40_00_00400000, 48'h80_00_00800000
	};
	pdrs_top uut (
		.clk_sys_in(clk), .rst_b_in(rst_b), .reg_sel_in(sel), .reg_wr_in(wen),
		.reg_addr_in(addr), .reg_be_in(be), .reg_wdata_in(wd), .reg_rdata_out(rdata),
		.eprom_load_fail_in(lv[6]), .line_busy_in(lv[7]), .wr_fifo_underrun_in(lv[5]),
		.wr_fifo_full_in(lv[4]), .wr_fifo_empty_in(lv[3]), .rd_fifo_overrun_in(lv[2]),
		.rd_fifo_full_in(lv[1]), .rd_fifo_empty_in(lv[0]), .trdy_timeout_in(ev[0]),
		.retry_timeout_in(ev[1]), .line_side_irq_in(ev[2]), .watchdog_expired_in(ev[3]),
		.target_abort_in(ev[4]), .master_abort_in(ev[5]), .wr_addr_match_in(ev[6]),
		.wr_end_of_buffer_in(ev[7]), .rd_xfer_done_in(done), .rd_active_out(act),
		.rd_current_address_out(cur), .irq_b_out(irq_b)
	);
	pdrs_mem_model mem (.clk_in(clk), .rd_active_in(act), .gap_in(gap), .xfer_done_out(done));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(negedge clk);
		{sel, wen, addr, wd, be} = {2'b11, a, v, 4'hf};
		@(negedge clk);
		{sel, wen} = 2'b00;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(negedge clk);
		{sel, wen, addr} = {2'b10, a};
		@(negedge clk);
		sel = 1'b0;
		@(negedge clk);
		v = rdata;
	endtask : rd
	task automatic run(input logic [31:0] c, input logic [3:0] g);
		logic [31:0] v;
		gap = g;
		wr(8'h00, 32'h0);
		wr(8'h00, c);
		repeat (2) @(negedge clk);
		for (int k = 0; k < 60 && act; k++) @(negedge clk);
		chk("active", 0, act);
		chk("cur_port", 32'h100c, cur);
		rd(8'h14, v);
		chk("cur_reg", 32'h100c, v);
	endtask : run
	task tally_and_finish;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	initial begin
		#125000;
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		{sel, wen, addr, wd, be, ev, lv, gap, rst_b} = '0;
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		chk("irq_rst", 1, irq_b);
		// 0x18 and 0x1c are unmapped and read zero
		for (int a = 0; a < 8; a++) begin
			rd(8'(a * 4), d);
			chk("reset", 0, d);
		end
		for (int i = 0; i < 16; i++) begin
			@(negedge clk);
			{lv, ev, e} = rows[i];
			@(negedge clk);
			ev = 8'h0;
			repeat (4) @(negedge clk);
			rd(8'h04, d);
			chk("status", e, d);
			wr(8'h04, 32'h0);
			rd(8'h04, d);
			chk("w0_keep", e, d);
			chk("irq_off", 1, irq_b);
			wr(8'h00, {7'h0, e[8:0], 16'h0});
			repeat (3) @(negedge clk);
			chk("irq_on", {31'h0, e[8:0] == 9'h0}, irq_b);
			wr(8'h04, 32'hffff_ffff);
			rd(8'h04, d);
			chk("w1_clr", e & 32'h00ff_0000, d);
			lv = 8'h0;
			wr(8'h00, 32'h0);
			repeat (4) @(negedge clk);
			rd(8'h04, d);
			chk("idle", 0, d);
			chk("irq_clr", 1, irq_b);
		end
		wr(8'h08, 32'h1000);
		wr(8'h0c, 32'h100c);
		wr(8'h10, 32'h1008);
		wr(8'h14, 32'hffff_ffff);
		rd(8'h08, d);
		chk("start", 32'h1000, d);
		rd(8'h0c, d);
		chk("stop", 32'h100c, d);
		rd(8'h10, d);
		chk("match", 32'h1008, d);
		rd(8'h14, d);
		chk("cur_ro", 0, d);
		run(32'h000c_0100, 4'h0);
		rd(8'h04, d);
		chk("rd_flags", 32'h0000_000c, d);
		chk("irq_rd", 0, irq_b);
		wr(8'h04, 32'h0000_000c);
		repeat (3) @(negedge clk);
		chk("irq_rd_clr", 1, irq_b);
		// slow partner, flags non-sticky
		run(32'h000c_0140, 4'h3);
		rd(8'h04, d);
		chk("nonsticky", 0, d);
		chk("irq_ns", 1, irq_b);
		// restart from the done state reloads the start address
		wr(8'h00, 32'h000c_0340);
		repeat (2) @(negedge clk);
		chk("restart_act", 1, act);
		chk("restart_cur", 32'h1000, cur);
		wr(8'h00, 32'h0);
		// a clear that meets a new event leaves the flag set
		@(negedge clk);
		{sel, wen, addr, wd, ev} = {2'b11, 8'h04, 32'h0000_0080, 8'h04};
		@(negedge clk);
		{sel, wen, ev} = '0;
		rd(8'h04, d);
		chk("set_wins", 32'h0000_0080, d);
		wr(8'h00, 32'h0080_0000);
		repeat (2) @(negedge clk);
		chk("irq_line", 0, irq_b);
		// reset with the line interrupt raised clears flags, registers and the interrupt
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		chk("irq_rst2", 1, irq_b);
		chk("cur_rst2", 0, cur);
		rd(8'h04, d);
		chk("status_rst2", 0, d);
		rd(8'h08, d);
		chk("start_rst2", 0, d);
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
